// [core/eeprom_rd_defs.vh]
// Purpose: Shared constants for the two-wire EEPROM target (read side, ID page, lock).
// Assumes: Included by bare name from core design files.
// Notes:   Definitions only.
`ifndef EEPROM_RD_DEFS_VH
`define EEPROM_RD_DEFS_VH

// Device type codes in the upper nibble of the address byte
`define ED_TYPE_ARRAY      4'hA
`define ED_TYPE_ID         4'hB

// Field positions
`define ED_RW_POS          0
`define ED_LOCK_SEL_POS    2
`define ED_LOCK_DATA_POS   1

// Array and identification page geometry
`define ED_ADDR_W          15
`define ED_ARRAY_DEPTH     32768
`define ED_PAGE_W          6
`define ED_PAGE_DEPTH      64

// Rising-edge counts within one nine-clock word
`define ED_BITS_DATA       4'h8
`define ED_BITS_WORD       4'h9

// Protocol states
`define ED_ST_IDLE         3'h0
`define ED_ST_DEVADDR      3'h1
`define ED_ST_ADDR_HI      3'h2
`define ED_ST_ADDR_LO      3'h3
`define ED_ST_WDATA        3'h4
`define ED_ST_RDATA        3'h5
`define ED_ST_WAITSTOP     3'h6

// Reset values
`define ED_RST_ADDR        15'h0000
`define ED_RST_OFF         6'h00
`define ED_RST_BYTE        8'h00

`endif

// [core/eeprom_target.v]
// Purpose: Two-wire EEPROM target: addressing, reads, ID page access and permanent lock.
// Assumes: SCL and SDA are oversampled by clk_sys_i (20 MHz) through two flops.
// Notes:   rst_i models power-up of a fresh part; nothing else clears the lock.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_rd_defs.vh"

// Functional notes
// - Lock command: ID type code, single byte write, lock select address bit high.
// - Lock takes effect only when data bit 1 of the byte is one.
// - After a valid lock the ID page stays read-only forever.
// - Direction bit one starts a read; current, random and sequential forms exist.
// - Address counter holds last accessed address plus one, kept between transactions.
// - Read counter wraps from top of array to address zero.
// - Current read: ack matching read address byte, send counter byte MSB first.
// - Random read sends the byte at the word address just loaded.
// - Controller acknowledge on a read byte advances counter and sends next byte.
// - Sequential read continues across the top at the wrapped address.
// - ID page read uses ID type code; low six address bits pick the byte.
// - That data byte is sent both when unlocked and when locked; the controller gives its acknowledge.
// - Each received word except locked ID data or an unmatched address byte is acknowledged by pulling SDA low on clock nine.
// - Address byte answered only if the three select bits match the straps.
// - Locked page: every ID write data byte unacknowledged and nothing programmed.
module eeprom_target #(
  parameter ADDR_W = `ED_ADDR_W,
  parameter DEPTH  = `ED_ARRAY_DEPTH,
  parameter PAGE_W = `ED_PAGE_W,
  parameter PDEPTH = `ED_PAGE_DEPTH
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire [2:0] chip_select_strap_i,
  output wire       id_locked_o
);
  wire [1:0]        pins_s;
  wire [2:0]        strap_s;
  wire              scl_s;
  wire              sda_s;
  reg               scl_q_ff;
  reg               sda_q_ff;
  wire              scl_rise;
  wire              scl_fall;
  wire              start_det;
  wire              stop_det;

  reg  [2:0]        state_ff;
  reg  [3:0]        bit_cnt_ff;
  reg  [7:0]        rx_ff;
  reg  [7:0]        tx_ff;
  reg  [7:0]        hi_ff;
  reg               sda_oe_ff;
  reg               is_id_ff;
  reg               lock_sel_ff;
  reg               lock_ff;
  reg               lock_pend_ff;
  reg               wbyte_seen_ff;
  reg               master_ack_ff;
  reg  [ADDR_W-1:0] addr_cnt_ff;
  reg  [PAGE_W-1:0] id_off_ff;

  wire [7:0]        arr_rdata;
  wire [7:0]        id_rdata;
  wire [7:0]        rd_byte;
  wire              type_arr;
  wire              type_id;
  wire              dev_match;
  wire              wdata_ack;
  wire              byte_done;
  wire              arr_we;
  wire              id_we;

  sync2 #(
    .WIDTH   (2),
    .RST_VAL (2'b11)
  ) u_sync_pins (
    .clk_i (clk_sys_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pins_s)
  );

  sync2 #(
    .WIDTH   (3),
    .RST_VAL (3'b000)
  ) u_sync_strap (
    .clk_i (clk_sys_i),
    .rst_i (rst_i),
    .d_i   (chip_select_strap_i),
    .q_o   (strap_s)
  );

  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  // Start and stop are SDA edges while SCL stays high
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  assign type_arr  = (rx_ff[7:4] == `ED_TYPE_ARRAY);
  assign type_id   = (rx_ff[7:4] == `ED_TYPE_ID);
  assign dev_match = (type_arr | type_id) & (rx_ff[3:1] == strap_s);
  // Locked page refuses every ID write data byte, status query included
  assign wdata_ack = is_id_ff ? ~lock_ff : 1'b1;
  assign byte_done = scl_fall & (bit_cnt_ff == `ED_BITS_DATA);

  assign arr_we = byte_done & (state_ff == `ED_ST_WDATA) & ~is_id_ff;
  // Lock command bytes never land in the page
  assign id_we  = byte_done & (state_ff == `ED_ST_WDATA) & is_id_ff
                  & ~lock_sel_ff & ~lock_ff;

  ff_mem #(
    .DW    (8),
    .AW    (ADDR_W),
    .DEPTH (DEPTH)
  ) u_array (
    .clk_i   (clk_sys_i),
    .we_i    (arr_we),
    .waddr_i (addr_cnt_ff),
    .wdata_i (rx_ff),
    .raddr_i (addr_cnt_ff),
    .rdata_o (arr_rdata)
  );

  ff_mem #(
    .DW    (8),
    .AW    (PAGE_W),
    .DEPTH (PDEPTH)
  ) u_id_page (
    .clk_i   (clk_sys_i),
    .we_i    (id_we),
    .waddr_i (id_off_ff),
    .wdata_i (rx_ff),
    .raddr_i (id_off_ff),
    .rdata_o (id_rdata)
  );

  assign rd_byte = is_id_ff ? id_rdata : arr_rdata;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q_ff      <= 1'b1;
      sda_q_ff      <= 1'b1;
      state_ff      <= `ED_ST_IDLE;
      bit_cnt_ff    <= 4'h0;
      rx_ff         <= `ED_RST_BYTE;
      tx_ff         <= `ED_RST_BYTE;
      hi_ff         <= `ED_RST_BYTE;
      sda_oe_ff     <= 1'b0;
      is_id_ff      <= 1'b0;
      lock_sel_ff   <= 1'b0;
      lock_ff       <= 1'b0;
      lock_pend_ff  <= 1'b0;
      wbyte_seen_ff <= 1'b0;
      master_ack_ff <= 1'b0;
      addr_cnt_ff   <= `ED_RST_ADDR;
      id_off_ff     <= `ED_RST_OFF;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      if (start_det) begin
        // Start also covers repeated start; a pending lock is dropped
        state_ff      <= `ED_ST_DEVADDR;
        bit_cnt_ff    <= 4'h0;
        sda_oe_ff     <= 1'b0;
        lock_pend_ff  <= 1'b0;
        wbyte_seen_ff <= 1'b0;
      end else if (stop_det) begin
        state_ff     <= `ED_ST_IDLE;
        bit_cnt_ff   <= 4'h0;
        sda_oe_ff    <= 1'b0;
        lock_pend_ff <= 1'b0;
        if (lock_pend_ff) begin
          lock_ff <= 1'b1;
        end
      end else if (state_ff != `ED_ST_IDLE && state_ff != `ED_ST_WAITSTOP) begin
        if (scl_rise) begin
          if (bit_cnt_ff < `ED_BITS_DATA) begin
            rx_ff <= {rx_ff[6:0], sda_s};
          end else begin
            master_ack_ff <= ~sda_s;
          end
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (byte_done) begin
          // Ninth clock: acknowledge received words, release after sent ones
          case (state_ff)
            `ED_ST_DEVADDR: begin
              if (dev_match) begin
                sda_oe_ff <= 1'b1;
                is_id_ff  <= type_id;
                // Write direction waits for the word end like any received word
                if (rx_ff[`ED_RW_POS]) begin
                  state_ff <= `ED_ST_RDATA;
                end
              end else begin
                state_ff <= `ED_ST_IDLE;
              end
            end
            `ED_ST_ADDR_HI: begin
              sda_oe_ff <= 1'b1;
              hi_ff     <= rx_ff;
            end
            `ED_ST_ADDR_LO: begin
              sda_oe_ff <= 1'b1;
              if (is_id_ff) begin
                // Upper bits ignored apart from the lock select
                id_off_ff   <= rx_ff[PAGE_W-1:0];
                lock_sel_ff <= hi_ff[`ED_LOCK_SEL_POS];
              end else begin
                addr_cnt_ff <= {hi_ff[ADDR_W-9:0], rx_ff};
              end
            end
            `ED_ST_WDATA: begin
              sda_oe_ff     <= wdata_ack;
              wbyte_seen_ff <= 1'b1;
              if (is_id_ff) begin
                if (lock_sel_ff && !lock_ff) begin
                  // Only a single qualifying byte arms the lock
                  lock_pend_ff <= ~wbyte_seen_ff
                                  & rx_ff[`ED_LOCK_DATA_POS];
                end else if (!lock_ff) begin
                  id_off_ff <= id_off_ff + 1'b1;
                end
              end else begin
                // Page write wraps within the current page
                addr_cnt_ff <= {addr_cnt_ff[ADDR_W-1:PAGE_W],
                                addr_cnt_ff[PAGE_W-1:0] + 1'b1};
              end
            end
            `ED_ST_RDATA: begin
              sda_oe_ff <= 1'b0;
            end
            default: begin
              state_ff <= `ED_ST_IDLE;
            end
          endcase
        end else if (scl_fall && bit_cnt_ff == `ED_BITS_WORD) begin
          bit_cnt_ff <= 4'h0;
          sda_oe_ff  <= 1'b0;
          case (state_ff)
            `ED_ST_DEVADDR: begin
              state_ff <= `ED_ST_ADDR_HI;
            end
            `ED_ST_ADDR_HI: begin
              state_ff <= `ED_ST_ADDR_LO;
            end
            `ED_ST_ADDR_LO: begin
              state_ff <= `ED_ST_WDATA;
            end
            `ED_ST_RDATA: begin
              // After the address word the sampled ack is our own low drive
              if (!master_ack_ff) begin
                // Controller declined: release so its stop can be seen
                state_ff <= `ED_ST_WAITSTOP;
              end else begin
                tx_ff     <= rd_byte;
                sda_oe_ff <= ~rd_byte[7];
                if (is_id_ff) begin
                  id_off_ff <= id_off_ff + 1'b1;
                end else begin
                  addr_cnt_ff <= addr_cnt_ff + 1'b1;
                end
              end
            end
            default: begin
            end
          endcase
        end else if (scl_fall && state_ff == `ED_ST_RDATA
                     && bit_cnt_ff != 4'h0 && bit_cnt_ff < `ED_BITS_DATA) begin
          sda_oe_ff <= ~tx_ff[6];
          tx_ff     <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_o       = 1'b0;
  assign sda_oe_o    = sda_oe_ff;
  assign id_locked_o = lock_ff;
endmodule
`default_nettype wire

// [core/ff_mem.v]
// Purpose: Flip-flop byte storage with one write port and one combinational read.
// Assumes: Writes are single-cycle pulses on the system clock.
// Notes:   Not reset; contents model nonvolatile cells.
`timescale 1ns/1ps
`default_nettype none
module ff_mem #(
  parameter DW    = 8,
  parameter AW    = 6,
  parameter DEPTH = 64
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output wire [DW-1:0] rdata_o
);
  reg [DW-1:0] cell_ff [0:DEPTH-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      cell_ff[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = cell_ff[raddr_i];
endmodule
`default_nettype wire

// [core/sync2.v]
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency needed.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter WIDTH   = 2,
  parameter RST_VAL = 2'b11
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule
`default_nettype wire

// [tb/eeprom_target_sva.sv]
// Purpose: Port-level checks for the two-wire EEPROM target.
// Assumes: SCL low and high phases each last at least four system clocks.
// Notes:   Bound to every eeprom_target instance.
`timescale 1ns/1ps
`default_nettype none
module eeprom_target_chk (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [2:0] chip_select_strap_i,
  input wire logic       id_locked_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_sda_o_low; !sda_o; endproperty
  a_sda_o_low: assert property (p_sda_o_low) else $error("sda_o not low");
  // Drive may only move in the SCL low phase, a few clocks after the fall
  property p_oe_after_fall;
    $changed(sda_oe_o) |-> !scl_i && ($past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5));
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall) else $error("sda drive moved off fall");
  property p_oe_stands; $changed(sda_oe_o) |=> $stable(sda_oe_o) [*6]; endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("sda drive did not stand");
  property p_idle_release; scl_i [*8] |-> !sda_oe_o; endproperty
  a_idle_release: assert property (p_idle_release) else $error("sda held on idle bus");
  property p_lock_at_stop; $rose(id_locked_o) |-> scl_i && sda_i; endproperty
  a_lock_at_stop: assert property (p_lock_at_stop) else $error("lock not at stop");
  property p_lock_sticky; !$fell(id_locked_o); endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
  property p_rst_oe; disable iff (1'b0) rst_i |-> !sda_oe_o; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("sda driven in reset");
  property p_rst_lock; disable iff (1'b0) rst_i |-> !id_locked_o; endproperty
  a_rst_lock: assert property (p_rst_lock) else $error("locked in reset");
endmodule
bind eeprom_target eeprom_target_chk i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .chip_select_strap_i(chip_select_strap_i), .id_locked_o(id_locked_o)
);
`default_nettype wire

// [tb/serial_eeprom_read_and_id_page_tb.sv]
// Purpose: Self-checking bench for reads, ID page access and lock of the EEPROM target.
// Assumes: Straps fixed at 3'h5, so addresses are A/B nibble with 101 select bits.
// Notes:   Lock is never cleared, so the lock scenario runs last.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_and_id_page_tb;
  logic       clk_sys_i;
  logic       rst_i;
  logic [2:0] chip_select_strap_i;
  logic       scl;
  logic       sda_low;
  wire        sda_o;
  wire        sda_oe_o;
  wire        id_locked_o;
  // Pull-up wire: low if either party pulls
  wire        sda = !(sda_low | sda_oe_o);
  int         n_fail;
  int         samples_checked;
  logic       nk;
  logic [7:0] d;
  eeprom_target i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_strap_i(chip_select_strap_i),
    .id_locked_o(id_locked_o));
  twi_ctl_model i_ctl (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp_nak);
    i_ctl.byte_w(b, nk);
    chk1("ack", exp_nak, nk);
  endtask
  task automatic get(input logic last, input logic [7:0] e);
    i_ctl.byte_r(last, d);
    chk8("rdata", e, d);
  endtask
  task automatic open(input logic [7:0] dev, input logic [7:0] hi, input logic [7:0] lo);
    i_ctl.start();
    send(dev, 1'b0);
    send(hi, 1'b0);
    send(lo, 1'b0);
  endtask
  task automatic rd_id(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e);
    open(8'hBA, hi, lo);
    i_ctl.start();
    send(8'hBB, 1'b0);
    get(1'b1, e);
    i_ctl.stop();
  endtask
  task automatic s_fill();
    open(8'hAA, 8'h7F, 8'hFE);
    send(8'h3C, 1'b0);
    send(8'hC5, 1'b0);
    i_ctl.stop();
    open(8'hAA, 8'h00, 8'h00);
    send(8'h5A, 1'b0);
    send(8'h96, 1'b0);
    send(8'h81, 1'b0);
    send(8'h42, 1'b0);
    i_ctl.stop();
  endtask
  task automatic s_seq_wrap();
    open(8'hAA, 8'h7F, 8'hFE);
    i_ctl.start();
    send(8'hAB, 1'b0);
    get(1'b0, 8'h3C);
    get(1'b0, 8'hC5);
    get(1'b0, 8'h5A);
    get(1'b1, 8'h96);
    i_ctl.stop();
    i_ctl.start();
    send(8'hAB, 1'b0);
    get(1'b1, 8'h81);
    i_ctl.stop();
  endtask
  task automatic s_strap();
    i_ctl.start();
    send(8'hA1, 1'b1);
    i_ctl.stop();
  endtask
  task automatic s_id();
    open(8'hBA, 8'h00, 8'h3F);
    send(8'hE7, 1'b0);
    send(8'h1B, 1'b0);
    i_ctl.stop();
    rd_id(8'hC0, 8'h3F, 8'hE7);
    rd_id(8'hFB, 8'hC0, 8'h1B);
    i_ctl.start();
    send(8'hAB, 1'b0);
    get(1'b1, 8'h42);
    i_ctl.stop();
  endtask
  task automatic s_lock();
    open(8'hBA, 8'h00, 8'h00);
    send(8'h00, 1'b0);
    i_ctl.start();
    i_ctl.stop();
    open(8'hBA, 8'h04, 8'h00);
    send(8'hFD, 1'b0);
    i_ctl.stop();
    chk1("locked", 1'b0, id_locked_o);
    open(8'hBA, 8'hFF, 8'hFF);
    send(8'h02, 1'b0);
    i_ctl.stop();
    chk1("locked", 1'b1, id_locked_o);
    open(8'hBA, 8'h00, 8'h00);
    send(8'h00, 1'b1);
    i_ctl.start();
    i_ctl.stop();
    open(8'hBA, 8'h00, 8'h3F);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    i_ctl.stop();
    rd_id(8'h00, 8'h3F, 8'hE7);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard: a stuck scenario ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_fail++;
    summarize();
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    chip_select_strap_i = 3'h5;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    i_ctl.wt(4);
    s_fill();
    s_seq_wrap();
    s_strap();
    s_id();
    s_lock();
    summarize();
  end
endmodule
`default_nettype wire

// [tb/twi_ctl_model.sv]
// Purpose: Two-wire bus controller model driving SCL and pulling SDA low.
// Assumes: 400 ns bit period, four system clocks low and four high.
// Notes:   SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module twi_ctl_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Release, raise SCL, then pull SDA: works as first or repeated start
  task automatic start();
    scl_o = 1'b0;
    sda_low_o = 1'b0;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    sda_low_o = 1'b1;
    wt(4);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    sda_low_o = 1'b0;
    wt(4);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = !b;
    wt(2);
    scl_o = 1'b1;
    wt(3);
    r = sda_i;
    wt(1);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic byte_w(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nak);
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule
`default_nettype wire
